// file: pam_pin_mux.sv
// Port alternate-function pin mux, top level
`timescale 1ns/1ps
module pam_pin_mux (
  // Clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 rstn_in,
  // Configuration
  input  wire logic [1:0]           interface_mode_field_in,
  input  wire logic [7:0]           port_a_alt_config_in,
  input  wire logic [7:0]           port_c_alt_config_in,
  input  wire logic [7:0]           port_e_alt_config_in,
  input  wire logic                 endpoint_fifo_wordwide_in,
  input  wire logic [7:0]           fifo_polarity_reg_in,
  input  wire logic                 timer2_ext_enable_in,
  // General-purpose port requests
  input  wire logic                 port_a_bit7_gpio_out_in,
  input  wire logic                 port_a_bit7_gpio_drive_in,
  input  wire pam_pkg::pam_gpio_t   port_b_gpio_in,
  input  wire pam_pkg::pam_gpio_t   port_c_gpio_in,
  input  wire pam_pkg::pam_gpio_t   port_d_gpio_in,
  input  wire pam_pkg::pam_gpio_t   port_e_gpio_in,
  // Alternate-function sources
  input  wire logic                 slave_fifo_flag_d_in,
  input  wire logic [15:0]          fifo_data_bus_in,
  input  wire logic                 fifo_data_drive_in,
  input  wire logic [8:0]           engine_address_in,
  input  wire pam_pkg::pam_timer_t  timer0_in,
  input  wire pam_pkg::pam_timer_t  timer1_in,
  input  wire logic                 timer2_ovf_in,
  input  wire pam_pkg::pam_uart_t   uart0_in,
  input  wire pam_pkg::pam_uart_t   uart1_in,
  // Pin inputs
  input  wire logic                 port_a_bit7_pin_in,
  input  wire logic [7:0]           port_b_pin_in,
  input  wire logic [7:0]           port_c_pin_in,
  input  wire logic [7:0]           port_d_pin_in,
  input  wire logic [7:0]           port_e_pin_in,
  input  wire logic [5:0]           ready_pin_in,
  // Pin outputs
  output logic                      port_a_bit7_out,
  output logic                      port_a_bit7_oe_n_out,
  output pam_pkg::pam_pins_t        port_b_pins_out,
  output pam_pkg::pam_pins_t        port_c_pins_out,
  output pam_pkg::pam_pins_t        port_d_pins_out,
  output pam_pkg::pam_pins_t        port_e_pins_out,
  // Inward results
  output logic                      port_a_bit7_read_out,
  output logic [7:0]                port_b_read_out,
  output logic [7:0]                port_c_read_out,
  output logic [7:0]                port_d_read_out,
  output logic [7:0]                port_e_read_out,
  output logic [15:0]               fifo_data_bus_out,
  output logic                      slave_fifo_read_strobe_out,
  output logic                      slave_fifo_write_strobe_out,
  output logic                      slave_fifo_select_out,
  output logic [5:0]                engine_ready_out,
  output logic                      ext_irq_pin_e5_out,
  output logic                      timer2_reload_input_out,
  output logic [2:0]                timer_overflow_pulse_out
);

  // ------
  // Pin synchronisers
  // ------
  logic [pam_pkg::SYNC_W-1:0] pins_async_w;
  logic [pam_pkg::SYNC_W-1:0] pins_sync_w;
  logic                       a7_s;
  logic [7:0]                 b_s;
  logic [7:0]                 c_s;
  logic [7:0]                 d_s;
  logic [7:0]                 e_s;
  logic [5:0]                 rdy_s;

  assign pins_async_w = {port_a_bit7_pin_in, port_b_pin_in, port_c_pin_in,
                         port_d_pin_in, port_e_pin_in, ready_pin_in};
  assign {a7_s, b_s, c_s, d_s, e_s, rdy_s} = pins_sync_w;

  pam_sync #(
    .W (pam_pkg::SYNC_W)
  ) u_sync (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .async_in (pins_async_w),
    .sync_out (pins_sync_w)
  );

  // ------
  // Mode decode
  // ------
  logic fifo_modes_w;
  logic slave_mode_w;
  logic engine_mode_w;
  logic a7_cs_sel_w;
  logic a7_flag_sel_w;
  logic wide_w;

  assign fifo_modes_w  = interface_mode_field_in[pam_pkg::IFM_FIFO_BIT];
  assign slave_mode_w  = (interface_mode_field_in == pam_pkg::IFM_SLAVE);
  assign engine_mode_w = (interface_mode_field_in == pam_pkg::IFM_ENGINE);
  // Chip select outranks the flag when both bits are set
  assign a7_cs_sel_w   = slave_mode_w &&
                         port_a_alt_config_in[pam_pkg::PA_CS_BIT];
  assign a7_flag_sel_w = fifo_modes_w && !a7_cs_sel_w &&
                         port_a_alt_config_in[pam_pkg::PA_FLAG_BIT];
  assign wide_w        = fifo_modes_w && endpoint_fifo_wordwide_in;

  // ------
  // Timer overflow pulses
  // ------
  pam_pkg::pam_timer_t tmr_w [3];
  logic [2:0]          tmr_pulse_w;

  assign tmr_w[0] = timer0_in;
  assign tmr_w[1] = timer1_in;
  // Timer 2 has no split mode
  assign tmr_w[2] = '{ovf: timer2_ovf_in, lo_ovf: 1'b0, mode: 2'h0};

  // Timers 0 and 1 stretch to an output-clock cycle, timer 2 to one clock
  generate
    for (genvar t = 0; t < 3; t++)
    begin : g_tmr
      pam_ovf_pulse #(
        .LEN ((t == 2) ? pam_pkg::T2_PULSE_CYC : pam_pkg::OUTCLK_CYC)
      ) u_pulse (
        .clock_in  (clock_in),
        .rstn_in   (rstn_in),
        .ovf_in    (tmr_w[t].ovf),
        .lo_ovf_in (tmr_w[t].lo_ovf),
        .mode_in   (tmr_w[t].mode),
        .pulse_out (tmr_pulse_w[t])
      );
    end
  endgenerate

  // ------
  // UART echo
  // ------
  logic rx0_echo_w;
  logic rx1_echo_w;

  assign rx0_echo_w = (uart0_in.mode == pam_pkg::UART_SYNC_MODE) ?
                      uart0_in.data : 1'b1;
  assign rx1_echo_w = (uart1_in.mode == pam_pkg::UART_SYNC_MODE) ?
                      uart1_in.data : 1'b1;

  // ------
  // Port E alternate sources, pin by pin
  // ------
  logic [7:0] e_alt_val_w;
  logic [7:0] e_alt_is_in_w;

  assign e_alt_val_w = {engine_address_in[8], 1'b0, 1'b0, rx1_echo_w,
                        rx0_echo_w, tmr_pulse_w};
  // Bits 5 and 6 become inputs when their alternate is chosen
  assign e_alt_is_in_w = 8'h60;

  // ------
  // Next pin state
  // ------
  logic               a7_out_nxt;
  logic               a7_oe_n_nxt;
  pam_pkg::pam_pins_t b_nxt;
  pam_pkg::pam_pins_t c_nxt;
  pam_pkg::pam_pins_t d_nxt;
  pam_pkg::pam_pins_t e_nxt;
  logic               fd_drive_w;

  // Device drives data only on FIFO request; the far end then stays off
  assign fd_drive_w  = fifo_modes_w && fifo_data_drive_in;

  assign a7_out_nxt  = a7_flag_sel_w ? slave_fifo_flag_d_in
                                     : port_a_bit7_gpio_out_in;
  assign a7_oe_n_nxt = a7_cs_sel_w   ? 1'b1 :
                       a7_flag_sel_w ? 1'b0 :
                       !port_a_bit7_gpio_drive_in;

  generate
    for (genvar i = 0; i < pam_pkg::PORT_W; i++)
    begin : g_pin
      // Port B: low data byte in FIFO and engine modes
      assign b_nxt.out[i]  = fifo_modes_w ? fifo_data_bus_in[i]
                                          : port_b_gpio_in.out[i];
      assign b_nxt.oe_n[i] = fifo_modes_w ? !fd_drive_w
                                          : !port_b_gpio_in.drive[i];
      // Port C: engine address per bit
      assign c_nxt.out[i]  = port_c_alt_config_in[i] ?
                             engine_address_in[i] : port_c_gpio_in.out[i];
      assign c_nxt.oe_n[i] = port_c_alt_config_in[i] ? 1'b0
                                          : !port_c_gpio_in.drive[i];
      // Port D: high data byte only when word-wide
      assign d_nxt.out[i]  = wide_w ? fifo_data_bus_in[8+i]
                                    : port_d_gpio_in.out[i];
      assign d_nxt.oe_n[i] = wide_w ? !fd_drive_w
                                    : !port_d_gpio_in.drive[i];
      // Port E: alternate output or released for alternate input
      assign e_nxt.out[i]  = port_e_alt_config_in[i] ? e_alt_val_w[i]
                                                     : port_e_gpio_in.out[i];
      assign e_nxt.oe_n[i] = port_e_alt_config_in[i] ? e_alt_is_in_w[i]
                                          : !port_e_gpio_in.drive[i];
    end
  endgenerate

  // ------
  // Strobes, chip select and ready inputs
  // ------
  logic cs_ok_w;
  logic rd_act_w;
  logic wr_act_w;

  // Without chip select in use the strobes are always heard in slave mode
  assign cs_ok_w  = !a7_cs_sel_w || !a7_s;
  assign rd_act_w = fifo_polarity_reg_in[pam_pkg::POL_RD_BIT] ?
                    rdy_s[0] : !rdy_s[0];
  assign wr_act_w = fifo_polarity_reg_in[pam_pkg::POL_WR_BIT] ?
                    rdy_s[1] : !rdy_s[1];

  // ------
  // Edge detect on port E inputs
  // ------
  logic e5_prev_r;
  logic e6_prev_r;
  logic irq_nxt;
  logic reload_nxt;

  assign irq_nxt    = port_e_alt_config_in[pam_pkg::PE_IRQ_BIT] &&
                      e_s[pam_pkg::PE_IRQ_BIT] && !e5_prev_r;
  assign reload_nxt = port_e_alt_config_in[pam_pkg::PE_TIMER2_RELOAD_INPUT_BIT] &&
                      timer2_ext_enable_in &&
                      !e_s[pam_pkg::PE_TIMER2_RELOAD_INPUT_BIT] && e6_prev_r;

  // ------
  // Pin output registers
  // ------
  // Registering routing adds one cycle but keeps pins glitch free
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      port_a_bit7_out      <= 1'b0;
      port_a_bit7_oe_n_out <= 1'b1;
      port_b_pins_out      <= '{out: pam_pkg::CFG_RST,
                                oe_n: pam_pkg::OE_N_RST};
      port_c_pins_out      <= '{out: pam_pkg::CFG_RST,
                                oe_n: pam_pkg::OE_N_RST};
      port_d_pins_out      <= '{out: pam_pkg::CFG_RST,
                                oe_n: pam_pkg::OE_N_RST};
      port_e_pins_out      <= '{out: pam_pkg::CFG_RST,
                                oe_n: pam_pkg::OE_N_RST};
    end
    else
    begin
      port_a_bit7_out      <= a7_out_nxt;
      port_a_bit7_oe_n_out <= a7_oe_n_nxt;
      port_b_pins_out      <= b_nxt;
      port_c_pins_out      <= c_nxt;
      port_d_pins_out      <= d_nxt;
      port_e_pins_out      <= e_nxt;
    end
  end

  // ------
  // Inward result registers
  // ------
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      port_a_bit7_read_out        <= 1'b0;
      port_b_read_out             <= '0;
      port_c_read_out             <= '0;
      port_d_read_out             <= '0;
      port_e_read_out             <= '0;
      fifo_data_bus_out           <= '0;
      slave_fifo_read_strobe_out  <= 1'b0;
      slave_fifo_write_strobe_out <= 1'b0;
      slave_fifo_select_out       <= 1'b0;
      engine_ready_out            <= '0;
      e5_prev_r                   <= 1'b0;
      e6_prev_r                   <= 1'b0;
      ext_irq_pin_e5_out          <= 1'b0;
      timer2_reload_input_out     <= 1'b0;
      timer_overflow_pulse_out    <= '0;
    end
    else
    begin
      port_a_bit7_read_out        <= a7_s;
      port_b_read_out             <= b_s;
      port_c_read_out             <= c_s;
      port_d_read_out             <= d_s;
      port_e_read_out             <= e_s;
      fifo_data_bus_out           <= {wide_w ? d_s : 8'h00, b_s};
      slave_fifo_read_strobe_out  <= slave_mode_w && cs_ok_w &&
                                     rd_act_w;
      slave_fifo_write_strobe_out <= slave_mode_w && cs_ok_w &&
                                     wr_act_w;
      slave_fifo_select_out       <= slave_mode_w && cs_ok_w;
      engine_ready_out            <= {rdy_s[5:2],
                                      engine_mode_w ? rdy_s[1:0]
                                                    : 2'b00};
      e5_prev_r                   <= e_s[pam_pkg::PE_IRQ_BIT];
      e6_prev_r                   <= e_s[pam_pkg::PE_TIMER2_RELOAD_INPUT_BIT];
      ext_irq_pin_e5_out          <= irq_nxt;
      timer2_reload_input_out     <= reload_nxt;
      timer_overflow_pulse_out    <= tmr_pulse_w;
    end
  end

endmodule

// file: pam_pkg.sv
// Constants and carrier types for the port alternate-function pin mux
//
// Functional notes
// - Port A bit 7: GPIO, FIFO flag out or chip select in.
// - In chip-select use, FIFO strobes count only while selected.
// - Port B: GPIO or FIFO data low byte; input after reset.
// - Port C pin n: engine address bit n when config bit n set.
// - Port D: FIFO data high byte in FIFO modes when word-wide.
// - Port E pin n: alternate function when config bit n set.
// - Timer 0 overflow pulse: high exactly one output-clock cycle.
// - Split-mode timer pulses on low-byte counter overflow.
// - Timer 1 overflow pulse: high one output-clock cycle.
// - Timer 2 overflow pulse: high one clock cycle.
// - UART 0 echo: data in sync mode 0, else one.
// - UART 1 echo: data in sync mode 0, high in modes 1 to 3.
// - Port E bit 5 alternate: rising-edge interrupt input.
// - Timer 2 reload input: falling edge, only when enabled.
// - Port E bit 7 alternate: engine address bit 8.
// - Ready 0: engine ready or FIFO read strobe, polarity bit 3.
// - Ready 1: engine ready or FIFO write strobe, polarity bit 2.
// - Ready pins 2 to 5: always engine inputs.
// - Port A config bit 7 selects flag, bit 6 chip select; reset 0.
package pam_pkg;

  // ------
  // Widths
  // ------
  localparam int PORT_W = 8;
  localparam int RDY_N  = 6;
  localparam int ADR_W  = 9;
  localparam int SYNC_W = 1 + 4 * PORT_W + RDY_N;

  // ------
  // Interface mode field codes
  // ------
  localparam logic [1:0] IFM_PORTS  = 2'h0;
  localparam logic [1:0] IFM_ENGINE = 2'h2;
  localparam logic [1:0] IFM_SLAVE  = 2'h3;
  localparam int         IFM_FIFO_BIT = 1;

  // ------
  // Field positions and reset values
  // ------
  localparam int PA_FLAG_BIT  = 7;
  localparam int PA_CS_BIT    = 6;
  localparam int POL_RD_BIT   = 3;
  localparam int POL_WR_BIT   = 2;
  localparam int PE_T0_BIT    = 0;
  localparam int PE_T2_BIT    = 2;
  localparam int PE_RX0_BIT   = 3;
  localparam int PE_RX1_BIT   = 4;
  localparam int PE_IRQ_BIT   = 5;
  localparam int PE_TIMER2_RELOAD_INPUT_BIT  = 6;
  localparam int PE_ADR8_BIT  = 7;
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] OE_N_RST = 8'hFF;
  localparam logic [1:0] TMR_SPLIT_MODE = 2'h3;
  localparam logic [1:0] UART_SYNC_MODE = 2'h0;

  // ------
  // Timing
  // ------
  localparam int CLK_PERIOD_NS    = 50;
  localparam int OUTCLK_PERIOD_NS = 50;
  localparam int OUTCLK_CYC = (OUTCLK_PERIOD_NS < CLK_PERIOD_NS) ? 1 :
                              OUTCLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int T2_PULSE_CYC = 1;

  // ------
  // Carrier types
  // ------
  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe_n;
  } pam_pins_t;

  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] drive;
  } pam_gpio_t;

  typedef struct packed {
    logic       ovf;
    logic       lo_ovf;
    logic [1:0] mode;
  } pam_timer_t;

  typedef struct packed {
    logic [1:0] mode;
    logic       data;
  } pam_uart_t;

endpackage

// file: pam_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pam_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock_in,
  input  wire logic         rstn_in,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// file: pam_ovf_pulse.sv
// Overflow pulse shaper: one event gives a pulse of LEN clock cycles
`timescale 1ns/1ps
module pam_ovf_pulse #(
  parameter int LEN = 1
) (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rstn_in,
  // Timer side
  input  wire logic         ovf_in,
  input  wire logic         lo_ovf_in,
  input  wire logic [1:0]   mode_in,
  // Pulse
  output logic              pulse_out
);

  localparam int CW = (LEN > 1) ? $clog2(LEN + 1) : 1;
  localparam logic [CW-1:0] LEN_C = CW'(LEN);

  logic          event_w;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // Split mode watches the low-byte counter
  assign event_w = (mode_in == pam_pkg::TMR_SPLIT_MODE) ? lo_ovf_in
                                                          : ovf_in;
  // A new overflow restarts the full pulse length
  assign cnt_nxt = event_w ? LEN_C :
                   (cnt_r != '0) ? cnt_r - CW'(1) : cnt_r;

  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      cnt_r     <= '0;
      pulse_out <= 1'b0;
    end
    else
    begin
      cnt_r     <= cnt_nxt;
      pulse_out <= (cnt_nxt != '0);
    end
  end

endmodule

// file: pam_pin_mux_asserts.sv
// Concurrent checks on the pin mux top-level ports
`timescale 1ns/1ps
module pam_pin_mux_asserts (
  // Clock, reset and configuration
  input wire logic                clock_in,
  input wire logic                rstn_in,
  input wire logic [1:0]          interface_mode_field_in,
  input wire logic [7:0]          port_a_alt_config_in,
  input wire logic [7:0]          port_c_alt_config_in,
  input wire logic [7:0]          port_e_alt_config_in,
  // Sources and pins
  input wire logic [8:0]          engine_address_in,
  input wire pam_pkg::pam_timer_t timer0_in,
  input wire pam_pkg::pam_timer_t timer1_in,
  input wire logic                timer2_ovf_in,
  input wire pam_pkg::pam_uart_t  uart0_in,
  input wire logic                port_a_bit7_pin_in,
  input wire logic [5:0]          ready_pin_in,
  // Outputs
  input wire logic                port_a_bit7_oe_n_out,
  input wire pam_pkg::pam_pins_t  port_b_pins_out,
  input wire pam_pkg::pam_pins_t  port_c_pins_out,
  input wire pam_pkg::pam_pins_t  port_e_pins_out,
  input wire logic                slave_fifo_read_strobe_out,
  input wire logic                slave_fifo_write_strobe_out,
  input wire logic [5:0]          engine_ready_out,
  input wire logic [2:0]          timer_overflow_pulse_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  logic [1:0] run_r;
  wire logic  sl_cs = interface_mode_field_in == pam_pkg::IFM_SLAVE &&
                      port_a_alt_config_in[6];
  wire logic  ev0 = timer0_in.mode == pam_pkg::TMR_SPLIT_MODE ?
                    timer0_in.lo_ovf : timer0_in.ovf;
  wire logic  ev1 = timer1_in.mode == pam_pkg::TMR_SPLIT_MODE ?
                    timer1_in.lo_ovf : timer1_in.ovf;
  // Cycles since reset release; pipelines are only valid once filled
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
      run_r <= 2'h0;
    else if (run_r != 2'h3)
      run_r <= run_r + 2'h1;
  end
  reset_inputs_a: assert property (
    $past(!rstn_in) |-> port_b_pins_out.oe_n == 8'hFF && port_a_bit7_oe_n_out)
    else $error("pins not released after reset");
  port_c_adr_a: assert property (run_r != 2'h0 |->
    (port_c_pins_out.oe_n & $past(port_c_alt_config_in)) == 8'h00 &&
    ((port_c_pins_out.out ^ $past(engine_address_in[7:0])) &
     $past(port_c_alt_config_in)) == 8'h00)
    else $error("port C address routing wrong");
  timer0_pulse_a: assert property (run_r >= 2'h2 |->
    timer_overflow_pulse_out[0] == $past(ev0, 2))
    else $error("timer 0 pulse wrong");
  timer1_pulse_a: assert property (run_r >= 2'h2 |->
    timer_overflow_pulse_out[1] == $past(ev1, 2))
    else $error("timer 1 pulse wrong");
  timer2_pulse_a: assert property (run_r >= 2'h2 |->
    timer_overflow_pulse_out[2] == $past(timer2_ovf_in, 2))
    else $error("timer 2 pulse wrong");
  uart0_echo_a: assert property (
    run_r != 2'h0 && $past(port_e_alt_config_in[3]) |->
    !port_e_pins_out.oe_n[3] && port_e_pins_out.out[3] ==
    ($past(uart0_in.mode) != 2'h0 || $past(uart0_in.data)))
    else $error("uart 0 echo wrong");
  adr8_drive_a: assert property (
    run_r != 2'h0 && $past(port_e_alt_config_in[7]) |->
    !port_e_pins_out.oe_n[7] &&
    port_e_pins_out.out[7] == $past(engine_address_in[8]))
    else $error("address bit 8 wrong");
  strobe_gate_a: assert property (run_r != 2'h0 &&
    $past(interface_mode_field_in) != pam_pkg::IFM_SLAVE |->
    !slave_fifo_read_strobe_out && !slave_fifo_write_strobe_out)
    else $error("strobe outside slave mode");
  cs_gate_a: assert property (run_r == 2'h3 && $past(sl_cs) |->
    port_a_bit7_oe_n_out && (!$past(port_a_bit7_pin_in, 3) ||
    !slave_fifo_read_strobe_out && !slave_fifo_write_strobe_out))
    else $error("chip select gating wrong");
  ready_follow_a: assert property (run_r == 2'h3 |->
    engine_ready_out[5:2] == $past(ready_pin_in[5:2], 3))
    else $error("ready 2 to 5 not followed");
  cover property (slave_fifo_read_strobe_out);
  cover property (timer_overflow_pulse_out[1]);
  cover property (engine_ready_out[5]);
endmodule

bind pam_pin_mux pam_pin_mux_asserts i_chk (.clock_in(clock_in),
  .rstn_in(rstn_in), .interface_mode_field_in(interface_mode_field_in),
  .port_a_alt_config_in(port_a_alt_config_in),
  .port_c_alt_config_in(port_c_alt_config_in),
  .port_e_alt_config_in(port_e_alt_config_in),
  .engine_address_in(engine_address_in), .timer0_in(timer0_in),
  .timer1_in(timer1_in), .timer2_ovf_in(timer2_ovf_in), .uart0_in(uart0_in),
  .port_a_bit7_pin_in(port_a_bit7_pin_in), .ready_pin_in(ready_pin_in),
  .port_a_bit7_oe_n_out(port_a_bit7_oe_n_out),
  .port_b_pins_out(port_b_pins_out), .port_c_pins_out(port_c_pins_out),
  .port_e_pins_out(port_e_pins_out),
  .slave_fifo_read_strobe_out(slave_fifo_read_strobe_out),
  .slave_fifo_write_strobe_out(slave_fifo_write_strobe_out),
  .engine_ready_out(engine_ready_out),
  .timer_overflow_pulse_out(timer_overflow_pulse_out));

// file: pam_far_model.sv
// Behavioural far-side FIFO master driving strobes, select and data pins
`timescale 1ns/1ps
module pam_far_model (
  // Clock and commands
  input  wire logic               clock_in,
  input  wire logic               rd_in,
  input  wire logic               wr_in,
  input  wire logic               cs_n_in,
  input  wire logic [7:0]         pol_in,
  input  wire logic [3:0]         rdy_hi_in,
  input  wire logic [15:0]        wdata_in,
  // Device pins
  input  wire logic               pa_out_in,
  input  wire logic               pa_oe_n_in,
  input  wire pam_pkg::pam_pins_t pb_in,
  input  wire pam_pkg::pam_pins_t pd_in,
  // Resolved pin levels
  output logic                    cs_pin_out,
  output logic      [5:0]         ready_out,
  output logic      [15:0]        data_out
);
  logic      [15:0] last_r = 16'h0000;
  wire logic [15:0] dev_oe_n = {pd_in.oe_n, pb_in.oe_n};
  wire logic [15:0] dev_out = {pd_in.out, pb_in.out};
  assign cs_pin_out = pa_oe_n_in ? cs_n_in : pa_out_in;
  assign ready_out = {rdy_hi_in, wr_in ~^ pol_in[2], rd_in ~^ pol_in[3]};
  // Released bits toggle so a stale level is never taken for data
  assign data_out = (~dev_oe_n & dev_out) |
                    (dev_oe_n & (wr_in ? wdata_in : ~last_r));
  always_ff @(posedge clock_in)
    last_r <= data_out;
endmodule

// file: tb_pam_pin_mux.sv
// Self-checking bench for the port alternate-function pin mux
`timescale 1ns/1ps
module tb_pam_pin_mux;
  logic                clock_in, rstn_in, wwide, fdrv, t2en, flag, t2;
  logic                rd, wr, csn, pa_pin, pa_out, pa_oe_n, rd_s, wr_s;
  logic                irq, rld, rda, sel;
  logic [1:0]          ifm;
  logic [7:0]          pa_cfg, pc_cfg, pe_cfg, pol, pe_pin, rdb, rdc, rdd, rde;
  logic [8:0]          adr;
  logic [15:0]         fdat, wdat, dpins, fbus;
  logic [3:0]          rhi;
  logic [5:0]          rdy, erdy;
  logic [2:0]          tovf;
  pam_pkg::pam_gpio_t  gp;
  pam_pkg::pam_timer_t t0, t1;
  pam_pkg::pam_uart_t  u0, u1;
  pam_pkg::pam_pins_t  pb, pc, pd, pe;
  int                  error_cnt = 0, checks_done = 0, cyc = 0;

  pam_pin_mux i_dut (.clock_in(clock_in), .rstn_in(rstn_in),
    .interface_mode_field_in(ifm), .port_a_alt_config_in(pa_cfg),
    .port_c_alt_config_in(pc_cfg), .port_e_alt_config_in(pe_cfg),
    .endpoint_fifo_wordwide_in(wwide), .fifo_polarity_reg_in(pol),
    .timer2_ext_enable_in(t2en), .port_a_bit7_gpio_out_in(1'h0),
    .port_a_bit7_gpio_drive_in(1'h0), .port_b_gpio_in(gp),
    .port_c_gpio_in(gp), .port_d_gpio_in(gp), .port_e_gpio_in(gp),
    .slave_fifo_flag_d_in(flag), .fifo_data_bus_in(fdat),
    .fifo_data_drive_in(fdrv), .engine_address_in(adr), .timer0_in(t0),
    .timer1_in(t1), .timer2_ovf_in(t2), .uart0_in(u0), .uart1_in(u1),
    .port_a_bit7_pin_in(pa_pin), .port_b_pin_in(dpins[7:0]),
    .port_c_pin_in(pc.out), .port_d_pin_in(dpins[15:8]),
    .port_e_pin_in(pe_pin), .ready_pin_in(rdy), .port_a_bit7_out(pa_out),
    .port_a_bit7_oe_n_out(pa_oe_n), .port_b_pins_out(pb),
    .port_c_pins_out(pc), .port_d_pins_out(pd), .port_e_pins_out(pe),
    .port_a_bit7_read_out(rda), .port_b_read_out(rdb), .port_c_read_out(rdc),
    .port_d_read_out(rdd), .port_e_read_out(rde), .fifo_data_bus_out(fbus),
    .slave_fifo_read_strobe_out(rd_s), .slave_fifo_write_strobe_out(wr_s),
    .slave_fifo_select_out(sel), .engine_ready_out(erdy),
    .ext_irq_pin_e5_out(irq), .timer2_reload_input_out(rld),
    .timer_overflow_pulse_out(tovf));

  pam_far_model i_far (.clock_in(clock_in), .rd_in(rd), .wr_in(wr),
    .cs_n_in(csn), .pol_in(pol), .rdy_hi_in(rhi), .wdata_in(wdat),
    .pa_out_in(pa_out), .pa_oe_n_in(pa_oe_n), .pb_in(pb), .pd_in(pd),
    .cs_pin_out(pa_pin), .ready_out(rdy), .data_out(dpins));

  initial
  begin
    clock_in = 1'h0;
    forever #25 clock_in = ~clock_in;
  end

  task automatic print_verdict;
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard: the run needs about 70 cycles
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  // Overflow on the sampling edge shows on the pins one edge later
  task automatic fire(input pam_pkg::pam_timer_t a, b, input logic c,
                      input logic [2:0] e);
    t0 = a;
    t1 = b;
    t2 = c;
    step(1);
    t0 = '0;
    t1 = '0;
    t2 = 1'h0;
    step(1);
    chk("tovf", 16'(e), 16'(tovf));
    chk("pe_tmr", 16'(e), 16'(pe.out[2:0]));
    step(1);
    chk("tovf_end", 16'h0000, 16'(tovf));
  endtask

  task automatic pulses(input logic w, input int e);
    int n = 0;
    repeat (8)
    begin
      step(1);
      if ((w ? rld : irq) === 1'h1)
        n++;
    end
    chk("pulses", 16'(e), 16'(n));
  endtask

  initial
  begin
    {rstn_in, ifm, pa_cfg, pc_cfg, pe_cfg, pol, wwide, fdrv, t2en} = '0;
    {flag, fdat, adr, t0, t1, t2, u0, u1, gp, pe_pin} = '0;
    {rd, wr, wdat, rhi} = '0;
    csn = 1'h1;
    step(2);
    rstn_in = 1'h1;
    step(1);
    chk("pb_oe", 16'h00FF, 16'(pb.oe_n));
    chk("pa_oe", 16'h0001, 16'(pa_oe_n));
    pc_cfg = 8'hA5;
    adr = 9'h1F3;
    step(1);
    chk("pc_oe", 16'h005A, 16'(pc.oe_n));
    chk("pc_adr", 16'h00A1, 16'(pc.out & 8'hA5));
    pe_cfg = 8'h9F;
    for (int m = 0; m < 4; m++)
    begin
      u0 = '{2'(m), 1'(m)};
      u1 = '{2'(m), ~1'(m)};
      step(1);
      chk("pe_echo", m == 0 ? 16'h0006 : 16'h0007,
          16'({pe.out[7], pe.out[4], pe.out[3]}));
    end
    chk("pe_oe", 16'h0060, 16'(pe.oe_n));
    fire('{1'h1, 1'h0, 2'h0}, '0, 1'h0, 3'h1);
    fire('{1'h1, 1'h0, 2'h3}, '{1'h0, 1'h1, 2'h3}, 1'h0, 3'h2);
    fire('{1'h0, 1'h1, 2'h3}, '{1'h0, 1'h1, 2'h1}, 1'h1, 3'h5);
    ifm = pam_pkg::IFM_SLAVE;
    pa_cfg = 8'h80;
    flag = 1'h1;
    step(1);
    chk("pa_flag", 16'h0001, 16'({pa_oe_n, pa_out}));
    pa_cfg = 8'h40;
    rd = 1'h1;
    step(3);
    chk("cs_off", 16'h000C, 16'({pa_oe_n, rda, sel, rd_s}));
    csn = 1'h0;
    step(3);
    chk("rd_low", 16'h0003, 16'({rda, sel, rd_s}));
    {rd, wr, pol, wwide, wdat} = {2'h1, 8'h04, 1'h1, 16'hBEEF};
    step(3);
    chk("wr_high", 16'h0001, 16'({rd_s, wr_s}));
    chk("fbus", 16'hBEEF, fbus);
    chk("rd_bd", 16'hBEEF, {rdd, rdb});
    {wr, fdrv, fdat} = {2'h1, 16'hC35A};
    step(1);
    chk("fd_out", 16'hC35A, {pd.out, pb.out});
    chk("fd_oe", 16'h0000, {pd.oe_n, pb.oe_n});
    wwide = 1'h0;
    gp = '{8'h3C, 8'h0F};
    step(1);
    chk("pd_gpio", 16'h00F0, 16'(pd.oe_n));
    {ifm, rd, pol, rhi} = {pam_pkg::IFM_ENGINE, 1'h1, 8'h08, 4'hA};
    step(3);
    chk("erdy", 16'h002B, 16'(erdy));
    chk("rd_eng", 16'h0000, 16'(rd_s));
    pe_cfg = 8'h60;
    step(3);
    pe_pin[5] = 1'h1;
    pulses(1'h0, 1);
    pe_pin[6] = 1'h1;
    step(3);
    pe_pin[6] = 1'h0;
    pulses(1'h1, 0);
    pe_pin[6] = 1'h1;
    step(3);
    {t2en, pe_pin[6]} = 2'h2;
    pulses(1'h1, 1);
    chk("rd_ce", 16'hB920, {rdc, rde});
    print_verdict();
  end
endmodule
